// ==== esp_consts.vh ====
// constants for the engine setup parameter group codec
`ifndef ESP_CONSTS_VH
`define ESP_CONSTS_VH
`define ESP_DATA_PAGE      1'h0
`define ESP_PDU_FMT        8'hFE
`define ESP_PS_SPD         8'hED
`define ESP_PS_TMP         8'hEE
`define ESP_PS_FLD         8'hEF
`define ESP_PRIO           3'h6
`define ESP_SRC_ADDR       8'h00
`define ESP_UNDEF_BYTE     8'hFF
`define ESP_UNDEF_WORD     16'hFFFF
`define ESP_BYTE_MAX       18'h000FA
`define ESP_OILT_RAW_MAX   16'hFB00
`define ESP_CCP_RAW_MAX    16'hFAFE
`define ESP_TEMP_OFS       9'h028
`define ESP_OILT_OFS       17'h02220
`define ESP_CCP_OFS        17'h07D00
`define ESP_PRES4_MAX      10'h3E8
`define ESP_PRES2_MAX      9'h1F4
`define ESP_LEVEL_MAX      10'h3E8
`define ESP_CLK_HZ         40000000
`define ESP_TMP_PERIOD_MS  1000
`define ESP_FLD_PERIOD_MS  500
`define ESP_TMP_CYC        (`ESP_CLK_HZ / 1000 * `ESP_TMP_PERIOD_MS)
`define ESP_FLD_CYC        (`ESP_CLK_HZ / 1000 * `ESP_FLD_PERIOD_MS)
`define ESP_FIFO_DEPTH     8
`define ESP_FIFO_AW        3
`define ESP_FRAME_W        93
`define ESP_ST_IDLE        2'h1
`define ESP_ST_PUSH        2'h2
`endif

// ==== esp_fifo.v ====
// frame fifo with valid/ready on both sides
module esp_fifo #(
  parameter W     = 93,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire         clk_sys,
  input  wire         reset_n,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;
  localparam [AW:0] FULL_CNT = DEPTH[AW:0];

  assign in_ready  = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // depth is a power of two, so the pointers wrap on their own
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // esp_fifo

// ==== esp_tick.v ====
// periodic one-cycle tick generator
module esp_tick #(
  parameter PERIOD = 40000000
) (
  input  wire clk_sys,
  input  wire reset_n,
  output reg  tick_q
);
  localparam [31:0] LAST = PERIOD - 1;
  reg [31:0] cnt_q;

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_q  <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q  <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end
endmodule // esp_tick

// ==== esp_codec.v ====
// packs and unpacks the speed setup, engine temperature and fluid groups
// Behaviour
// - speed setup: PGN 65261, on request, bytes 4-8 undefined
// - byte 1 max vehicle speed, 1 km/h
// - byte 2 cruise upper set limit, 1 km/h
// - byte 3 cruise lower set limit, 1 km/h
// - temperature group PGN 65262 every 1 s
// - one-byte temps 1 degree, offset -40
// - oil temps 1/32 degree, offset -273, two bytes
// - fluid group PGN 65263 every 0.5 s
// - fuel and oil pressure 4 kPa per count
// - oil and coolant level 0.4 percent per count
// - crankcase pressure 1/128 kPa, offset -250
// - coolant pressure 2 kPa per count
`include "esp_consts.vh"
module esp_codec #(
  parameter TMP_PERIOD_CYC = `ESP_TMP_CYC,
  parameter FLD_PERIOD_CYC = `ESP_FLD_CYC,
  parameter [7:0] SRC_ADDR = `ESP_SRC_ADDR
) (
  input  wire               clk_sys,
  input  wire               reset_n,
  input  wire               spd_req,
  input  wire [7:0]         tx_spd_max_kph,
  input  wire [7:0]         tx_cc_hi_kph,
  input  wire [7:0]         tx_cc_lo_kph,
  input  wire signed [8:0]  tx_cool_temp_c,
  input  wire signed [8:0]  tx_fuel_temp_c,
  input  wire signed [16:0] tx_oil_temp_c32,
  input  wire signed [16:0] tx_turbo_temp_c32,
  input  wire signed [8:0]  tx_icool_temp_c,
  input  wire [9:0]         tx_fuel_pres_kpa,
  input  wire [9:0]         tx_oil_level_pm,
  input  wire [9:0]         tx_oil_pres_kpa,
  input  wire signed [16:0] tx_case_pres_k128,
  input  wire [8:0]         tx_cool_pres_kpa,
  input  wire [9:0]         tx_cool_level_pm,
  output wire               tx_valid,
  input  wire               tx_ready,
  output wire [28:0]        tx_id,
  output wire [63:0]        tx_data,
  output reg                tx_range_err_q,
  input  wire               rx_valid,
  input  wire [28:0]        rx_id,
  input  wire [63:0]        rx_data,
  output reg                rx_spd_upd_q,
  output reg                rx_tmp_upd_q,
  output reg                rx_fld_upd_q,
  output reg  [7:0]         rx_spd_max_kph_q,
  output reg  [7:0]         rx_cc_hi_kph_q,
  output reg  [7:0]         rx_cc_lo_kph_q,
  output reg  [2:0]         rx_spd_ok_q,
  output reg  signed [8:0]  rx_cool_temp_c_q,
  output reg  signed [8:0]  rx_fuel_temp_c_q,
  output reg  signed [16:0] rx_oil_temp_c32_q,
  output reg  signed [16:0] rx_turbo_temp_c32_q,
  output reg  signed [8:0]  rx_icool_temp_c_q,
  output reg  [4:0]         rx_tmp_ok_q,
  output reg  [9:0]         rx_fuel_pres_kpa_q,
  output reg  [9:0]         rx_oil_level_pm_q,
  output reg  [9:0]         rx_oil_pres_kpa_q,
  output reg  signed [16:0] rx_case_pres_k128_q,
  output reg  [8:0]         rx_cool_pres_kpa_q,
  output reg  [9:0]         rx_cool_level_pm_q,
  output reg  [5:0]         rx_fld_ok_q
);
  localparam ST_IDLE = `ESP_ST_IDLE;
  localparam ST_PUSH = `ESP_ST_PUSH;

  // byte field: negative or above 250 counts goes out as all ones
  function [7:0] fn_byte;
    input [17:0] raw;
    begin
      if (raw[17] || (raw > `ESP_BYTE_MAX)) begin
        fn_byte = `ESP_UNDEF_BYTE;
      end else begin
        fn_byte = raw[7:0];
      end
    end
  endfunction

  function [15:0] fn_word;
    input [17:0] raw;
    input [15:0] max;
    begin
      if (raw[17] || raw[16] || (raw[15:0] > max)) begin
        fn_word = `ESP_UNDEF_WORD;
      end else begin
        fn_word = raw[15:0];
      end
    end
  endfunction

  function fn_ok8;
    input [7:0] raw;
    begin
      fn_ok8 = ({10'h000, raw} <= `ESP_BYTE_MAX);
    end
  endfunction

  function [28:0] fn_id;
    input [7:0] ps;
    input [7:0] sa;
    begin
      fn_id = {`ESP_PRIO, 1'b0, `ESP_DATA_PAGE, `ESP_PDU_FMT, ps, sa};
    end
  endfunction

  // data page and format are common to all three groups
  function fn_rx_hit;
    input [28:0] id;
    input [7:0]  ps;
    begin
      fn_rx_hit = (id[24] == `ESP_DATA_PAGE) & (id[23:16] == `ESP_PDU_FMT)
                & (id[15:8] == ps);
    end
  endfunction

  wire        tmp_tick;
  wire        fld_tick;
  reg  [1:0]  state_q;
  reg  [2:0]  pend_q;
  reg  [2:0]  pend_d;
  reg  [2:0]  sel_q;
  reg  [`ESP_FRAME_W-1:0] frame_q;
  wire        fifo_in_ready;
  wire        fifo_in_valid;
  wire        push_done;
  wire [2:0]  evt;
  wire [`ESP_FRAME_W-1:0] fifo_out;

  esp_tick #(.PERIOD(TMP_PERIOD_CYC)) u_tmp_tick (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tick_q  (tmp_tick)
  );

  esp_tick #(.PERIOD(FLD_PERIOD_CYC)) u_fld_tick (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tick_q  (fld_tick)
  );

  // transmit raw values, scaled from physical units
  wire [17:0] r_cool  = {{9{tx_cool_temp_c[8]}}, tx_cool_temp_c}
                        + {9'h000, `ESP_TEMP_OFS};
  wire [17:0] r_fuelt = {{9{tx_fuel_temp_c[8]}}, tx_fuel_temp_c}
                        + {9'h000, `ESP_TEMP_OFS};
  wire [17:0] r_icool = {{9{tx_icool_temp_c[8]}}, tx_icool_temp_c}
                        + {9'h000, `ESP_TEMP_OFS};
  wire [17:0] r_oilt  = {tx_oil_temp_c32[16], tx_oil_temp_c32}
                        + {1'b0, `ESP_OILT_OFS};
  wire [17:0] r_turbo = {tx_turbo_temp_c32[16], tx_turbo_temp_c32}
                        + {1'b0, `ESP_OILT_OFS};
  wire [17:0] r_case  = {tx_case_pres_k128[16], tx_case_pres_k128}
                        + {1'b0, `ESP_CCP_OFS};
  // physical limit checked before the shift, since truncation hides overshoot
  wire [17:0] r_fuelp = (tx_fuel_pres_kpa > `ESP_PRES4_MAX) ? 18'h3FFFF :
                        {10'h000, tx_fuel_pres_kpa[9:2]};
  wire [17:0] r_oilp  = (tx_oil_pres_kpa > `ESP_PRES4_MAX) ? 18'h3FFFF :
                        {10'h000, tx_oil_pres_kpa[9:2]};
  wire [17:0] r_oill  = (tx_oil_level_pm > `ESP_LEVEL_MAX) ? 18'h3FFFF :
                        {10'h000, tx_oil_level_pm[9:2]};
  wire [17:0] r_cooll = (tx_cool_level_pm > `ESP_LEVEL_MAX) ? 18'h3FFFF :
                        {10'h000, tx_cool_level_pm[9:2]};
  wire [17:0] r_coolp = (tx_cool_pres_kpa > `ESP_PRES2_MAX) ? 18'h3FFFF :
                        {10'h000, tx_cool_pres_kpa[8:1]};

  wire [15:0] w_oilt  = fn_word(r_oilt, `ESP_OILT_RAW_MAX);
  wire [15:0] w_turbo = fn_word(r_turbo, `ESP_OILT_RAW_MAX);
  wire [15:0] w_case  = fn_word(r_case, `ESP_CCP_RAW_MAX);

  // payload byte n sits at bits 8n-1..8n-8
  wire [63:0] pay_spd = {{5{`ESP_UNDEF_BYTE}},
                         fn_byte({10'h000, tx_cc_lo_kph}),
                         fn_byte({10'h000, tx_cc_hi_kph}),
                         fn_byte({10'h000, tx_spd_max_kph})};
  wire [63:0] pay_tmp = {`ESP_UNDEF_BYTE,
                         fn_byte(r_icool),
                         w_turbo[15:8], w_turbo[7:0],
                         w_oilt[15:8], w_oilt[7:0],
                         fn_byte(r_fuelt), fn_byte(r_cool)};
  wire [63:0] pay_fld = {fn_byte(r_cooll), fn_byte(r_coolp),
                         w_case[15:8], w_case[7:0],
                         fn_byte(r_oilp), fn_byte(r_oill),
                         `ESP_UNDEF_BYTE,
                         fn_byte(r_fuelp)};

  // valid raws never reach all ones, so all ones marks a clipped field
  wire bad_spd = (pay_spd[7:0] == `ESP_UNDEF_BYTE) | (pay_spd[15:8] == `ESP_UNDEF_BYTE)
               | (pay_spd[23:16] == `ESP_UNDEF_BYTE);
  wire bad_tmp = (pay_tmp[7:0] == `ESP_UNDEF_BYTE) | (pay_tmp[15:8] == `ESP_UNDEF_BYTE)
               | (w_oilt == `ESP_UNDEF_WORD) | (w_turbo == `ESP_UNDEF_WORD)
               | (pay_tmp[55:48] == `ESP_UNDEF_BYTE);
  wire bad_fld = (pay_fld[7:0] == `ESP_UNDEF_BYTE) | (pay_fld[23:16] == `ESP_UNDEF_BYTE)
               | (pay_fld[31:24] == `ESP_UNDEF_BYTE) | (w_case == `ESP_UNDEF_WORD)
               | (pay_fld[55:48] == `ESP_UNDEF_BYTE) | (pay_fld[63:56] == `ESP_UNDEF_BYTE);

  // speed setup only on request, the others on their own timers
  assign evt       = {fld_tick, tmp_tick, spd_req};
  assign fifo_in_valid = (state_q == ST_PUSH);
  assign push_done     = fifo_in_valid & fifo_in_ready;

  // a new event in the clearing cycle keeps its pending bit
  always @* begin
    pend_d = pend_q | evt;
    if (push_done) begin
      pend_d = (pend_q & ~sel_q) | evt;
    end
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q        <= ST_IDLE;
      pend_q         <= 3'h0;
      sel_q          <= 3'h0;
      frame_q        <= {`ESP_FRAME_W{1'b0}};
      tx_range_err_q <= 1'b0;
    end else begin
      pend_q         <= pend_d;
      // one pulse per built frame with a clipped field, not sticky
      tx_range_err_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // fixed priority: request answer first, then the faster group
          if (pend_q[0]) begin
            sel_q          <= 3'h1;
            frame_q        <= {fn_id(`ESP_PS_SPD, SRC_ADDR), pay_spd};
            tx_range_err_q <= bad_spd;
            state_q        <= ST_PUSH;
          end else if (pend_q[2]) begin
            sel_q          <= 3'h4;
            frame_q        <= {fn_id(`ESP_PS_FLD, SRC_ADDR), pay_fld};
            tx_range_err_q <= bad_fld;
            state_q        <= ST_PUSH;
          end else if (pend_q[1]) begin
            sel_q          <= 3'h2;
            frame_q        <= {fn_id(`ESP_PS_TMP, SRC_ADDR), pay_tmp};
            tx_range_err_q <= bad_tmp;
            state_q        <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (fifo_in_ready) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // back-pressure from the message layer stalls the packer in ST_PUSH
  esp_fifo #(
    .W     (`ESP_FRAME_W),
    .DEPTH (`ESP_FIFO_DEPTH),
    .AW    (`ESP_FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (frame_q),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (fifo_out)
  );

  assign tx_id   = fifo_out[`ESP_FRAME_W-1:64];
  assign tx_data = fifo_out[63:0];

  // receive side: priority and source address are not matched
  wire rx_spd = rx_valid & fn_rx_hit(rx_id, `ESP_PS_SPD);
  wire rx_tmp = rx_valid & fn_rx_hit(rx_id, `ESP_PS_TMP);
  wire rx_fld = rx_valid & fn_rx_hit(rx_id, `ESP_PS_FLD);
  wire [15:0] rx_w_oilt  = {rx_data[31:24], rx_data[23:16]};
  wire [15:0] rx_w_turbo = {rx_data[47:40], rx_data[39:32]};
  wire [15:0] rx_w_case  = {rx_data[47:40], rx_data[39:32]};

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      rx_spd_upd_q        <= 1'b0;
      rx_tmp_upd_q        <= 1'b0;
      rx_fld_upd_q        <= 1'b0;
      rx_spd_max_kph_q    <= 8'h00;
      rx_cc_hi_kph_q      <= 8'h00;
      rx_cc_lo_kph_q      <= 8'h00;
      rx_spd_ok_q         <= 3'h0;
      rx_cool_temp_c_q    <= 9'h000;
      rx_fuel_temp_c_q    <= 9'h000;
      rx_oil_temp_c32_q   <= 17'h00000;
      rx_turbo_temp_c32_q <= 17'h00000;
      rx_icool_temp_c_q   <= 9'h000;
      rx_tmp_ok_q         <= 5'h00;
      rx_fuel_pres_kpa_q  <= 10'h000;
      rx_oil_level_pm_q   <= 10'h000;
      rx_oil_pres_kpa_q   <= 10'h000;
      rx_case_pres_k128_q <= 17'h00000;
      rx_cool_pres_kpa_q  <= 9'h000;
      rx_cool_level_pm_q  <= 10'h000;
      rx_fld_ok_q         <= 6'h00;
    end else begin
      rx_spd_upd_q <= rx_spd;
      rx_tmp_upd_q <= rx_tmp;
      rx_fld_upd_q <= rx_fld;
      // bytes 4-8 of the setup frame are ignored
      if (rx_spd) begin
        rx_spd_max_kph_q <= rx_data[7:0];
        rx_cc_hi_kph_q   <= rx_data[15:8];
        rx_cc_lo_kph_q   <= rx_data[23:16];
        rx_spd_ok_q      <= {fn_ok8(rx_data[23:16]), fn_ok8(rx_data[15:8]),
                             fn_ok8(rx_data[7:0])};
      end
      // values land even with the ok bit clear; users gate on it
      if (rx_tmp) begin
        rx_cool_temp_c_q    <= {1'b0, rx_data[7:0]} - `ESP_TEMP_OFS;
        rx_fuel_temp_c_q    <= {1'b0, rx_data[15:8]} - `ESP_TEMP_OFS;
        rx_oil_temp_c32_q   <= {1'b0, rx_w_oilt} - `ESP_OILT_OFS;
        rx_turbo_temp_c32_q <= {1'b0, rx_w_turbo} - `ESP_OILT_OFS;
        rx_icool_temp_c_q   <= {1'b0, rx_data[55:48]} - `ESP_TEMP_OFS;
        rx_tmp_ok_q <= {fn_ok8(rx_data[55:48]),
                        (rx_w_turbo <= `ESP_OILT_RAW_MAX),
                        (rx_w_oilt <= `ESP_OILT_RAW_MAX),
                        fn_ok8(rx_data[15:8]), fn_ok8(rx_data[7:0])};
      end
      if (rx_fld) begin
        rx_fuel_pres_kpa_q  <= {rx_data[7:0], 2'b00};
        rx_oil_level_pm_q   <= {rx_data[23:16], 2'b00};
        rx_oil_pres_kpa_q   <= {rx_data[31:24], 2'b00};
        rx_case_pres_k128_q <= {1'b0, rx_w_case} - `ESP_CCP_OFS;
        rx_cool_pres_kpa_q  <= {rx_data[55:48], 1'b0};
        rx_cool_level_pm_q  <= {rx_data[63:56], 2'b00};
        rx_fld_ok_q <= {fn_ok8(rx_data[63:56]), fn_ok8(rx_data[55:48]),
                        (rx_w_case <= `ESP_CCP_RAW_MAX),
                        fn_ok8(rx_data[31:24]), fn_ok8(rx_data[23:16]),
                        fn_ok8(rx_data[7:0])};
      end
    end
  end
endmodule // esp_codec

// ==== esp_codec_checker.sv ====
// port checker for the parameter group codec
module esp_codec_checker #(
  parameter [7:0] SRC_ADDR = 8'h00
) (
  input wire               clk_sys,
  input wire               reset_n,
  input wire               tx_valid,
  input wire               tx_ready,
  input wire [28:0]        tx_id,
  input wire [63:0]        tx_data,
  input wire               rx_valid,
  input wire [28:0]        rx_id,
  input wire [63:0]        rx_data,
  input wire               rx_spd_upd_q,
  input wire               rx_tmp_upd_q,
  input wire               rx_fld_upd_q,
  input wire [7:0]         rx_spd_max_kph_q,
  input wire signed [8:0]  rx_cool_temp_c_q,
  input wire signed [16:0] rx_oil_temp_c32_q,
  input wire [9:0]         rx_fuel_pres_kpa_q,
  input wire signed [16:0] rx_case_pres_k128_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire       hit = rx_valid && rx_id[24:16] == 9'h0FE;
  wire       m_s = hit && rx_id[15:8] == 8'hED;
  wire       m_t = hit && rx_id[15:8] == 8'hEE;
  wire       m_f = hit && rx_id[15:8] == 8'hEF;
  // gated so the filler checks need no separate valid term
  wire [7:0] ps  = tx_valid ? tx_id[15:8] : 8'h00;

  a_tx_hold_stall: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_id) && $stable(tx_data)) else $error("tx frame moved");
  a_tx_id_fields: assert property (tx_valid |-> tx_id[28:16] == 13'h18FE &&
    tx_id[7:0] == SRC_ADDR && ps inside {8'hED, 8'hEE, 8'hEF}) else $error("bad tx id");
  a_spd_undef_ones: assert property (ps == 8'hED |-> tx_data[63:24] == 40'hFFFFFFFFFF)
    else $error("speed filler wrong");
  a_tmp_undef_ones: assert property (ps == 8'hEE |-> tx_data[63:56] == 8'hFF)
    else $error("temp filler wrong");
  a_fld_undef_ones: assert property (ps == 8'hEF |-> tx_data[15:8] == 8'hFF)
    else $error("fluid filler wrong");
  a_spd_in_range: assert property (ps == 8'hED |->
    (tx_data[7:0] <= 8'hFA || &tx_data[7:0]) && (tx_data[15:8] <= 8'hFA || &tx_data[15:8])
    && (tx_data[23:16] <= 8'hFA || &tx_data[23:16])) else $error("speed field out of range");
  a_rx_spd_copy: assert property (m_s |=> rx_spd_upd_q &&
    rx_spd_max_kph_q == $past(rx_data[7:0])) else $error("rx speed wrong");
  a_rx_tmp_scale: assert property (m_t |=> rx_tmp_upd_q &&
    rx_cool_temp_c_q == {1'b0, $past(rx_data[7:0])} - 9'h028 &&
    rx_oil_temp_c32_q == {1'b0, $past(rx_data[31:16])} - 17'h02220) else $error("rx temp wrong");
  a_rx_fld_scale: assert property (m_f |=> rx_fld_upd_q &&
    rx_fuel_pres_kpa_q == {$past(rx_data[7:0]), 2'b00} &&
    rx_case_pres_k128_q == {1'b0, $past(rx_data[47:32])} - 17'h07D00) else $error("rx fluid wrong");
  a_rx_other_quiet: assert property (!(m_s || m_t || m_f) |=>
    !rx_spd_upd_q && !rx_tmp_upd_q && !rx_fld_upd_q) else $error("stray rx update");
endmodule // esp_codec_checker

bind esp_codec esp_codec_checker #(.SRC_ADDR(SRC_ADDR)) u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_id(tx_id), .tx_data(tx_data), .rx_valid(rx_valid), .rx_id(rx_id), .rx_data(rx_data),
  .rx_spd_upd_q(rx_spd_upd_q), .rx_tmp_upd_q(rx_tmp_upd_q), .rx_fld_upd_q(rx_fld_upd_q),
  .rx_spd_max_kph_q(rx_spd_max_kph_q), .rx_cool_temp_c_q(rx_cool_temp_c_q),
  .rx_oil_temp_c32_q(rx_oil_temp_c32_q), .rx_fuel_pres_kpa_q(rx_fuel_pres_kpa_q),
  .rx_case_pres_k128_q(rx_case_pres_k128_q));

// ==== esp_msg_layer.sv ====
// message layer model: logs taken tx frames, injects rx frames
module esp_msg_layer (
  input  wire         clk_sys,
  input  wire         stall,
  input  wire         tx_valid,
  output logic        tx_ready,
  input  wire  [28:0] tx_id,
  input  wire  [63:0] tx_data,
  output logic        rx_valid,
  output logic [28:0] rx_id,
  output logic [63:0] rx_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [28:0] q_id[$];
  logic [63:0] q_data[$];
  int          q_cyc[$];
  int          cyc = 0;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_id    = 29'h0;
    rx_data  = 64'h0;
  end
  always @(negedge clk_sys) tx_ready <= !stall;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (tx_valid && tx_ready) begin
      q_id.push_back(tx_id);
      q_data.push_back(tx_data);
      q_cyc.push_back(cyc);
    end
  end
  task automatic drop();
    q_id.delete(0);
    q_data.delete(0);
    q_cyc.delete(0);
  endtask
  task automatic flush();
    q_id.delete();
    q_data.delete();
    q_cyc.delete();
  endtask
  // strobe for one cycle; afterwards the bus shows the inverse, never a stale frame
  task automatic send(input logic [28:0] id, input logic [63:0] d);
    @(negedge clk_sys);
    rx_valid = 1'b1;
    rx_id    = id;
    rx_data  = d;
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_id    = ~id;
    rx_data  = ~d;
  endtask
endmodule // esp_msg_layer

// ==== esp_codec_tb_top.sv ====
// testbench for the parameter group codec
module esp_codec_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TMP = 40;
  localparam int FLD = 20;
  logic               clk_sys, reset_n, spd_req, stall, err_seen;
  logic        [7:0]  s_max, s_hi, s_lo;
  logic        [8:0]  t_cool, t_fuel, t_ic, f_cp;
  logic        [16:0] t_oil, t_tur, f_case;
  logic        [9:0]  f_fp, f_ol, f_op, f_cl;
  wire                tx_valid, tx_ready, rx_valid, tx_err, s_upd, t_upd, f_upd;
  wire         [28:0] tx_id, rx_id;
  wire         [63:0] tx_data, rx_data;
  wire         [7:0]  s_rmax, s_rhi, s_rlo;
  wire         [2:0]  s_ok;
  wire         [4:0]  t_ok;
  wire         [5:0]  f_ok;
  wire         [8:0]  r_cool, r_fuel, r_ic, r_cp;
  wire         [16:0] r_oil, r_tur, r_case;
  wire         [9:0]  r_fp, r_ol, r_op, r_cl;
  int                 fail_count = 0, num_checks = 0, cycles = 0;

  esp_codec #(.TMP_PERIOD_CYC(TMP), .FLD_PERIOD_CYC(FLD)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .spd_req(spd_req), .tx_spd_max_kph(s_max),
    .tx_cc_hi_kph(s_hi), .tx_cc_lo_kph(s_lo), .tx_cool_temp_c(t_cool), .tx_fuel_temp_c(t_fuel),
    .tx_oil_temp_c32(t_oil), .tx_turbo_temp_c32(t_tur), .tx_icool_temp_c(t_ic),
    .tx_fuel_pres_kpa(f_fp), .tx_oil_level_pm(f_ol), .tx_oil_pres_kpa(f_op),
    .tx_case_pres_k128(f_case), .tx_cool_pres_kpa(f_cp), .tx_cool_level_pm(f_cl),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_data(tx_data),
    .tx_range_err_q(tx_err), .rx_valid(rx_valid), .rx_id(rx_id), .rx_data(rx_data),
    .rx_spd_upd_q(s_upd), .rx_tmp_upd_q(t_upd), .rx_fld_upd_q(f_upd),
    .rx_spd_max_kph_q(s_rmax), .rx_cc_hi_kph_q(s_rhi), .rx_cc_lo_kph_q(s_rlo),
    .rx_spd_ok_q(s_ok), .rx_cool_temp_c_q(r_cool), .rx_fuel_temp_c_q(r_fuel),
    .rx_oil_temp_c32_q(r_oil), .rx_turbo_temp_c32_q(r_tur), .rx_icool_temp_c_q(r_ic),
    .rx_tmp_ok_q(t_ok), .rx_fuel_pres_kpa_q(r_fp), .rx_oil_level_pm_q(r_ol),
    .rx_oil_pres_kpa_q(r_op), .rx_case_pres_k128_q(r_case), .rx_cool_pres_kpa_q(r_cp),
    .rx_cool_level_pm_q(r_cl), .rx_fld_ok_q(f_ok));
  esp_msg_layer u_pm (.clk_sys(clk_sys), .stall(stall), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_id(tx_id), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_id(rx_id), .rx_data(rx_data));

  task automatic chk(input logic [63:0] act, input logic [63:0] exp);
    num_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // skips frames of other groups; the id of the one taken is judged here
  task automatic get(input logic [7:0] ps, output logic [63:0] d, output int c);
    d = 64'h0;
    c = 0;
    repeat (400) begin
      @(negedge clk_sys);
      while (u_pm.q_id.size() > 0 && u_pm.q_id[0][15:8] != ps) u_pm.drop();
      if (u_pm.q_id.size() > 0) begin
        chk(64'(u_pm.q_id[0]), 64'({13'h18FE, ps, 8'h00}));
        d = u_pm.q_data[0];
        c = u_pm.q_cyc[0];
        u_pm.drop();
        return;
      end
    end
    chk(64'h0, 64'h1);
  endtask
  task automatic pulse();
    spd_req = 1'b1;
    @(negedge clk_sys);
    spd_req = 1'b0;
  endtask
  task automatic t_speed();
    logic [63:0] d;
    int          c;
    {s_max, s_hi, s_lo} = {8'hFA, 8'h82, 8'h00};
    pulse();
    get(8'hED, d, c);
    chk(d, {40'hFFFFFFFFFF, 8'h00, 8'h82, 8'hFA});
    err_seen = 1'b0;
    s_max = 8'hFB;
    pulse();
    get(8'hED, d, c);
    chk({d[7:0], 7'h0, err_seen}, 16'hFF01);
  endtask
  task automatic t_temp();
    logic [63:0] d;
    int          c0, c1;
    {t_cool, t_fuel, t_ic} = {9'h05A, 9'h1D8, 9'h0D2};
    t_oil = 17'h00C80;
    t_tur = 17'h0D8E0;
    get(8'hEE, d, c0);
    get(8'hEE, d, c0);
    get(8'hEE, d, c1);
    chk(d, {8'hFF, 8'hFA, 16'hFB00, 16'h2EA0, 8'h00, 8'h82});
    chk(64'(c1 - c0), 64'(TMP));
  endtask
  task automatic t_fluid();
    logic [63:0] d;
    int          c0, c1;
    {f_fp, f_ol, f_op, f_cl} = {10'h3E8, 10'h3E8, 10'h004, 10'h004};
    f_cp = 9'h1F4;
    get(8'hEF, d, c0);
    get(8'hEF, d, c0);
    get(8'hEF, d, c1);
    chk(d, {8'h01, 8'hFA, 16'h7D00, 8'h01, 8'hFA, 8'hFF, 8'hFA});
    chk(64'(c1 - c0), 64'(FLD));
  endtask
  task automatic t_rx();
    u_pm.send({5'h0C, 16'hFEED, 8'h55}, {40'h0, 8'h0A, 8'hFB, 8'hFA});
    chk(64'({s_upd, s_ok, s_rmax, s_rhi, s_rlo}), 64'({4'hD, 24'hFAFB0A}));
    u_pm.send({5'h18, 16'hFEEE, 8'h00}, {8'hFF, 8'hFA, 16'h0000, 16'hFB01, 8'h28, 8'h00});
    chk(64'({t_upd, t_ok, r_cool, r_fuel, r_ic}), 64'({6'h3B, 27'h76000D2}));
    chk(64'({r_oil, r_tur}), 64'({17'h0D8E1, 17'h1DDE0}));
    u_pm.send({5'h18, 16'hFEEF, 8'h00}, {24'h00FAFA, 16'hFF01, 24'hFBFFFA});
    chk(64'({f_upd, f_ok, r_fp, r_ol}), 64'({1'b1, 6'h35, 10'h3E8, 10'h3EC}));
    chk(64'({r_op, r_cp, r_cl, r_case}), 64'({10'h004, 9'h1F4, 10'h000, 17'h07DFF}));
    u_pm.send({5'h18, 16'hFEF0, 8'h00}, 64'h0);
    chk({s_upd, t_upd, f_upd}, 3'h0);
    u_pm.send({5'h19, 16'hFEED, 8'h00}, 64'h0);
    chk({s_upd, s_rmax}, 9'h0FA);
  endtask
  // fill the fifo behind a stalled consumer, then expect a back-to-back drain
  task automatic t_fifo();
    int i;
    stall = 1'b1;
    @(negedge clk_sys);
    u_pm.flush();
    repeat (300) @(negedge clk_sys);
    chk(64'({u_pm.q_id.size(), tx_valid}), 64'h1);
    stall = 1'b0;
    repeat (20) @(negedge clk_sys);
    for (i = 1; i < 8; i++) chk(64'(u_pm.q_cyc[i] - u_pm.q_cyc[i - 1]), 64'h1);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (tx_err) err_seen = 1'b1;
    if (cycles == 4000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    {reset_n, spd_req, stall, err_seen} = 4'h0;
    {s_max, s_hi, s_lo, t_cool, t_fuel, t_ic, f_cp} = 60'h0;
    {t_oil, t_tur, f_case, f_fp, f_ol, f_op, f_cl} = 91'h0;
    repeat (4) @(negedge clk_sys);
    chk({tx_valid, s_upd, t_upd, f_upd, tx_err}, 5'h0);
    reset_n = 1'b1;
    t_speed();
    t_temp();
    t_fluid();
    t_rx();
    t_fifo();
    complete_run();
  end
endmodule // esp_codec_tb_top
